// ===== design/sync_exec.sv
module sync_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Instruction issue
    input wire logic i_valid,
    input wire instr_t i_instr,
    output logic o_ready,
    output logic o_done,
    // Register file write port for loading operands
    input wire logic i_reg_we,
    input wire logic [2:0] i_reg_idx,
    input wire logic [15:0] i_reg_wdata,
    // Register file read port
    input wire logic [2:0] i_rd_idx,
    output logic [15:0] o_rd_data,
    // Flags
    output flags_t o_flags,
    // Peripheral bus on the sync clock
    output logic o_sync_clk,
    output logic o_per_we,
    output store_t o_per_store
);

    // ==========================================================
    // State
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_LOW = 2'b01,
        ST_DRIVE = 2'b10,
        ST_FINISH = 2'b11
    } state_t;

    state_t state;
    state_t next_state;
    logic [15:0] regs [REG_COUNT];
    logic [15:0] next_regs [REG_COUNT];
    flags_t flags;
    flags_t next_flags;
    logic [3:0] div_cnt;
    logic [3:0] next_div_cnt;
    logic sync_clk;
    logic next_sync_clk;
    logic per_we;
    logic next_per_we;
    store_t store;
    store_t next_store;
    logic done;
    logic next_done;
    logic [15:0] rd_data;
    logic [15:0] next_rd_data;

    logic [31:0] product;
    flags_t mul_flags;
    logic sync_fall;
    logic [2:0] odd_reg;

    // ==========================================================
    // Multiplier operands
    // The product is worked out every cycle from the offered
    // instruction; it only lands when a multiply is taken.
    logic [15:0] mul_dest;
    logic [15:0] mul_src;

    assign mul_dest = regs[i_instr.dest_reg];
    assign mul_src = i_instr.src_operand;

    unsigned_mul u_mul (
        .i_dest(mul_dest),
        .i_src(mul_src),
        .i_word_size(i_instr.word_size),
        .o_product(product),
        .o_flags(mul_flags)
    );

    assign odd_reg = i_instr.dest_reg | 3'h1;

    // ==========================================================
    // Sync clock divider: free running so the peripheral sees a
    // steady clock; stores line up with its falling edge.
    always_comb begin
        next_div_cnt = div_cnt + 4'h1;
        next_sync_clk = sync_clk;
        if (div_cnt == SYNC_HALF_CNT) begin
            next_div_cnt = 4'h0;
            next_sync_clk = ~sync_clk;
        end
    end

    assign sync_fall = (div_cnt == SYNC_HALF_CNT) && sync_clk;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= 4'h0;
            sync_clk <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            sync_clk <= next_sync_clk;
        end
    end

    // ==========================================================
    // Issue decode
    // Only the idle state takes an instruction; anything offered
    // while a store is in flight is dropped, so wait for done.
    // An operation code of none is ignored.
    logic issue;
    logic issue_mul;
    logic issue_store;

    assign issue = i_valid && (state == ST_IDLE);
    assign issue_mul = issue && (i_instr.op == OP_MUL);
    assign issue_store = issue && (i_instr.op == OP_SYNC_STORE);

    // ==========================================================
    // Sequencer
    // Idle, wait for a falling sync edge, drive one period, finish.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (issue_store) begin
                    next_state = ST_WAIT_LOW;
                end
            end
            ST_WAIT_LOW: begin
                // Launch the access on a falling sync edge
                if (sync_fall) begin
                    next_state = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                // Hold the strobe over one full sync period
                if (sync_fall) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // One cycle so done follows the end of the strobe
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Register file
    // A load in the same cycle as a multiply loses to the product.
    // An odd word destination takes both halves in one register and
    // keeps the lower one; software must not rely on that.
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            next_regs[i] = regs[i];
        end
        if (i_reg_we && state == ST_IDLE) begin
            next_regs[i_reg_idx] = i_reg_wdata;
        end
        if (issue_mul) begin
            if (i_instr.word_size) begin
                // Upper half to even register
                next_regs[i_instr.dest_reg] =
                    product[31:16];
                next_regs[odd_reg] = product[15:0];
            end else begin
                next_regs[i_instr.dest_reg] = product[15:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // ==========================================================
    // Condition flags
    // Only a multiply touches the flags; a store leaves them alone.
    always_comb begin
        next_flags = flags;
        if (issue_mul) begin
            next_flags = mul_flags;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ==========================================================
    // Peripheral write strobe
    always_comb begin
        next_per_we = per_we;
        if (state == ST_WAIT_LOW && sync_fall) begin
            next_per_we = 1'b1;
        end else if (state == ST_DRIVE && sync_fall) begin
            next_per_we = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            per_we <= 1'b0;
        end else begin
            per_we <= next_per_we;
        end
    end

    // ==========================================================
    // Peripheral address and data
    // Latched at issue and held until the next store, so a slow
    // peripheral may sample them late in the window.
    always_comb begin
        next_store = store;
        if (issue_store) begin
            // Byte operand only; upper bits are not carried
            next_store.addr = i_instr.dest_addr;
            next_store.data =
                regs[i_instr.source_register][7:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            store <= '0;
        end else begin
            store <= next_store;
        end
    end

    // ==========================================================
    // Completion pulse
    always_comb begin
        next_done = issue_mul || (state == ST_FINISH);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end

    // ==========================================================
    // Register read port
    // One cycle of latency, readable at any time, even mid-store.
    always_comb begin
        next_rd_data = regs[i_rd_idx];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data <= REG_RESET;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign o_ready = (state == ST_IDLE);
    assign o_done = done;
    assign o_flags = flags;
    assign o_sync_clk = sync_clk;
    assign o_per_we = per_we;
    assign o_per_store = store;
    assign o_rd_data = rd_data;

endmodule

// ===== design/exec_pkg.sv
package exec_pkg;

    // ==========================================================
    // Register file and operand geometry
    localparam int REG_COUNT = 8;
    localparam int REG_IDX_W = 3;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int PROD_W = 32;
    localparam int ADDR_W = 16;

    // ==========================================================
    // Reset values
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // ==========================================================
    // Peripheral sync clock: the core clock divided by this count
    localparam int SYNC_DIV = 10;
    localparam int SYNC_HALF = SYNC_DIV / 2;
    localparam logic [3:0] SYNC_HALF_CNT = 4'(SYNC_HALF - 1);

    // ==========================================================
    // Operations
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_SYNC_STORE = 2'b01,
        OP_MUL = 2'b10
    } op_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_t;

    typedef struct packed {
        op_t op;
        logic word_size;
        logic [2:0] dest_reg;
        logic [2:0] source_register;
        logic [15:0] src_operand;
        logic [15:0] dest_addr;
    } instr_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } store_t;

endpackage

// ===== design/unsigned_mul.sv
module unsigned_mul
    import exec_pkg::*;
(
    // Operands
    input wire logic [15:0] i_dest,
    input wire logic [15:0] i_src,
    input wire logic i_word_size,
    // Result
    output logic [31:0] o_product,
    output flags_t o_flags
);

    logic [31:0] product;

    always_comb begin
        if (i_word_size) begin
            product = 32'(i_dest) * 32'(i_src);
        end else begin
            product = {16'h0000,
                16'(i_dest[7:0]) * 16'(i_src[7:0])};
        end
        o_product = product;
        if (i_word_size) begin
            o_flags.n = product[31];
        end else begin
            o_flags.n = product[15];
        end
        o_flags.z = (product == 32'h0000_0000);
        o_flags.v = 1'b0;
        o_flags.c = 1'b0;
    end

endmodule

// ===== testbench/sync_exec_chk.sv
module sync_exec_chk
    import exec_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire instr_t i_instr,
    input wire logic o_ready,
    input wire logic o_done,
    input wire flags_t o_flags,
    input wire logic o_sync_clk,
    input wire logic o_per_we,
    input wire store_t o_per_store
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire go = i_valid && o_ready;
    // ==========
    // Sequences
    sequence sync_half(logic lv);
        (o_sync_clk == lv) [*5];
    endsequence
    sequence we_hold;
        o_per_we [*8] ##1 o_per_we [*2] ##1 !o_per_we;
    endsequence
    a_sync_period: assert property (
        $rose(o_sync_clk) |-> sync_half(1'b1) ##1 sync_half(1'b0) ##1 o_sync_clk)
        else $error("sync clock period wrong");
    a_we_on_fall: assert property ($rose(o_per_we) |-> $fell(o_sync_clk))
        else $error("strobe not on sync fall");
    a_we_window: assert property ($rose(o_per_we) |-> we_hold)
        else $error("strobe window wrong");
    a_done_after: assert property ($fell(o_per_we) |=> o_done)
        else $error("no done after store");
    a_store_hold: assert property (o_per_we |-> $stable(o_per_store))
        else $error("store moved in window");
    a_store_busy: assert property (
        go && i_instr.op == OP_SYNC_STORE |=> !o_ready)
        else $error("store did not block");
    a_flags_keep: assert property (!o_ready |=> $stable(o_flags))
        else $error("flags moved in store");
    a_mul_vc: assert property (
        go && i_instr.op == OP_MUL |=> o_done && !o_flags.v && !o_flags.c)
        else $error("multiply v or c set");
    a_zero_prod: assert property (
        go && i_instr.op == OP_MUL && i_instr.src_operand == 16'h0000
        |=> o_flags.z && !o_flags.n)
        else $error("zero product flags wrong");
endmodule

bind sync_exec sync_exec_chk sync_exec_chk_inst(.*);

// ===== testbench/periph_model.sv
module periph_model
    import exec_pkg::*;
(
    // Bus from the core
    input wire logic i_clk,
    input wire logic i_sync_clk,
    input wire logic i_per_we,
    input wire store_t i_store,
    // Captured write
    output logic o_got,
    output store_t o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic we_q;
    // Write lands as the window closes, sync clock low
    always_ff @(posedge i_clk) begin
        we_q <= i_per_we;
        o_got <= we_q && !i_per_we && !i_sync_clk;
        if (we_q && !i_per_we) begin
            o_data <= i_store;
        end
    end
endmodule

// ===== testbench/sync_peripheral_store_and_unsigned_mul_test.sv
module sync_peripheral_store_and_unsigned_mul_test;
    import exec_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_valid = 1'b0;
    logic i_reg_we = 1'b0;
    instr_t i_instr = '0;
    logic [2:0] i_reg_idx = 3'h0;
    logic [2:0] i_rd_idx = 3'h0;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic o_ready, o_done, o_sync_clk, o_per_we, got;
    logic rd_req = 1'b0;
    logic rd_q = 1'b0;
    logic [15:0] o_rd_data;
    flags_t o_flags;
    flags_t ef = FLAGS_RESET;
    store_t o_per_store, pdata;
    logic [15:0] rf [8];
    logic [31:0] q [$];
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    sync_exec sync_exec_inst(.*);
    periph_model periph_model_inst(.i_clk(i_clk), .i_sync_clk(o_sync_clk),
        .i_per_we(o_per_we), .i_store(o_per_store), .o_got(got),
        .o_data(pdata));
    initial forever #50 i_clk = ~i_clk;
    // ==========
    // Checking
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_store(input store_t g, input logic [31:0] e);
        chk(32'(g), e);
    endtask
    task automatic chk_flags(input flags_t g, input logic [31:0] e);
        chk(32'(g), e);
    endtask
    task automatic chk_reg(input logic [15:0] g, input logic [31:0] e);
        chk(32'(g), e);
    endtask
    always @(negedge i_clk) begin
        if (got === 1'b1) chk_store(pdata, q.pop_front());
        if (o_done === 1'b1) begin
            chk_flags(o_flags, q.pop_front());
        end
        if (rd_q) begin
            chk_reg(o_rd_data, q.pop_front());
        end
    end
    // Bound on run length; a hung store never reaches it, as each store wait gives up after 40 cycles
    always @(posedge i_clk) begin
        rd_q <= rd_req;
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end
    // ==========
    // Drivers
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic load(input logic [2:0] r, input logic [15:0] v);
        i_reg_we <= 1'b1;
        i_reg_idx <= r;
        i_reg_wdata <= v;
        rf[r] = v;
        tick();
        i_reg_we <= 1'b0;
        tick();
    endtask
    task automatic rd(input logic [2:0] r);
        i_rd_idx <= r;
        rd_req <= 1'b1;
        q.push_back({16'h0000, rf[r]});
        tick();
        rd_req <= 1'b0;
        tick();
    endtask
    task automatic run(input op_t op, input logic w, input logic [2:0] d,
        input logic [15:0] v, input logic [15:0] a);
        i_instr <= '{op, w, d, 3'h7 - d, v, a};
        i_valid <= 1'b1;
        tick();
        i_valid <= 1'b0;
    endtask
    initial begin
        logic [15:0] a, b, v;
        logic [31:0] p;
        logic [2:0] d;
        void'($urandom(32'hE31CB6A5));
        for (int k = 0; k < 8; k++) rf[k] = REG_RESET;
        tick(6);
        i_rst_n <= 1'b1;
        tick();
        for (int t = 0; t < 12; t++) begin
            d = 3'($urandom_range(3)) << 1;
            a = 16'($urandom);
            b = (t % 4 == 0) ? 16'h0000 : 16'($urandom);
            load(d, a);
            load(d + 3'h1, 16'($urandom));
            p = t[0] ? a * b : {16'h0000, 16'(a[7:0]) * b[7:0]};
            ef = '{t[0] ? p[31] : p[15], p == 32'h0, 1'b0, 1'b0};
            q.push_back({28'h0, ef});
            run(OP_MUL, t[0], d, b, a);
            if (t[0]) begin
                rf[d] = p[31:16];
                rf[d + 3'h1] = p[15:0];
            end else begin
                rf[d] = p[15:0];
            end
            rd(d);
            rd(d + 3'h1);
            v = 16'($urandom);
            load(3'h7 - d, v);
            q.push_back({8'h00, a, v[7:0]});
            q.push_back({28'h0, ef});
            run(OP_SYNC_STORE, 1'b0, d, 16'h0000, a);
            for (int w = 0; w < 40 && o_done !== 1'b1; w++) @(negedge i_clk);
            tick();
        end
        tick(3);
        stop_test();
    end
endmodule
